//--- bench/mcs_scope_unit_tb_top.sv
// Self-checking bench for the machine-check error scope unit.
// Assumes the constants header is on the include path; no partner model.
`timescale 1ns/1ps
`include "mcs_params.svh"

module mcs_scope_unit_tb_top;
  import mcs_pkg::*;
  logic ref_clk, rst, clk_en, en, cap, rep, bclr, ipclr, context_corrupt, uc, dfr, poi, ovf, av, mv, rip, eip;
  logic [1:0] bank, cbank, vbank;
  logic [3:0] lv;
  logic alv, mlv, rec, ripo, eipo, cip, exq, shut;
  logic [7:0] vec;
  mcs_scope_t scope;
  int n_errors = 0;
  int checks_done = 0;
  // Rows: pcc uc dfr poi rip eip ovf cap
  logic [7:0] tbl [8] = '{8'hcd, 8'h4e, 8'h57, 8'h20, 8'h00, 8'h48, 8'h30, 8'h4d};
  mcs_scope_t exp_sc [8] = '{MCS_SCOPE_FATAL, MCS_SCOPE_RECOVERABLE, MCS_SCOPE_CONTAINABLE,
    MCS_SCOPE_DEFERRED, MCS_SCOPE_CORRECTED, MCS_SCOPE_UNCLASSIFIED, MCS_SCOPE_UNCLASSIFIED,
    MCS_SCOPE_RECOVERABLE};

  mcs_scope_unit u_dut (.ref_clk(ref_clk), .rst(rst), .clk_en(clk_en),
    .check_exception_enable(en), .overflow_recovery_capable(cap), .err_report(rep),
    .err_bank(bank), .err_context_corrupt(context_corrupt), .err_uncorrected_flag(uc), .err_deferred(dfr),
    .err_poison(poi), .err_overflow(ovf), .err_address_log_valid(av), .err_misc_log_valid(mv),
    .err_restart_ip_valid(rip), .err_error_ip_valid(eip), .bank_clear(bclr), .clear_bank(cbank),
    .in_progress_clear(ipclr), .view_bank(vbank), .log_valid(lv), .address_log_valid(alv),
    .misc_log_valid(mlv), .scope(scope), .recovery_possible(rec), .restart_ip_valid(ripo),
    .error_ip_valid(eipo), .check_in_progress(cip), .exception_req(exq),
    .exception_vector(vec), .shutdown(shut));

  always #10 ref_clk = ~ref_clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic do_reset();
    rst = 1'b1;
    repeat (6) @(negedge ref_clk);
    rst = 1'b0;
    chk({shut, cip, exq, lv}, 8'h00);
    chk(scope, MCS_SCOPE_NONE);
  endtask

  // Report from table row i into bank b; returns after the taking edge
  task automatic report(input int i, input logic [1:0] b);
    {context_corrupt, uc, dfr, poi, rip, eip, ovf, cap} = tbl[i];
    {mv, av} = 2'(i);
    bank = b;
    vbank = b;
    rep = 1'b1;
    @(negedge ref_clk);
    rep = 1'b0;
  endtask

  initial
  begin
    #200us;
    n_errors++;
    summarize();
  end

  initial
  begin
    ref_clk = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    en = 1'b1;
    rep = 1'b0;
    bclr = 1'b0;
    ipclr = 1'b0;
    cbank = 2'h0;
    vbank = 2'h0;
    do_reset();
    @(negedge ref_clk);
    for (int i = 0; i < 8; i++)
    begin
      report(i, 2'(i));
      chk({exq, cip}, {uc, uc});
      @(negedge ref_clk);
      chk(lv[i % 4], 1'b1);
      chk(scope, exp_sc[i]);
      chk(rec, !context_corrupt && !(ovf && !cap));
      chk({alv, mlv}, {av, mv});
      if (uc)
      begin
        chk(ripo, rip);
        chk(eipo, eip);
        chk(vec, `MCS_VECTOR);
      end
      chk(shut, 1'b0);
      bclr = 1'b1;
      ipclr = 1'b1;
      cbank = 2'(i);
      @(negedge ref_clk);
      bclr = 1'b0;
      ipclr = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk(lv[i % 4], 1'b0);
      chk(cip, 1'b0);
    end
    // Scan every bank as a handler would; empty ones must read scope none
    report(4, 2'h1);
    @(negedge ref_clk);
    report(3, 2'h2);
    @(negedge ref_clk);
    for (int b = 0; b < `MCS_NUM_BANKS; b++)
    begin
      vbank = 2'(b);
      @(negedge ref_clk);
      chk(lv[b], (b == 1 || b == 2));
      if (lv[b])
        chk(scope, (b == 1) ? MCS_SCOPE_CORRECTED : MCS_SCOPE_DEFERRED);
      else
        chk(scope, MCS_SCOPE_NONE);
    end
    // Second uncorrected report while one is still in progress
    report(7, 2'h0);
    chk({exq, cip}, 2'b11);
    @(negedge ref_clk);
    report(0, 2'h1);
    chk({exq, shut}, 2'b01);
    @(negedge ref_clk);
    report(1, 2'h2);
    chk({exq, shut}, 2'b01);
    // Mid-run reset, then a report with the clock enable low is ignored
    do_reset();
    clk_en = 1'b0;
    report(7, 2'h3);
    @(negedge ref_clk);
    chk({lv, exq, cip}, 6'h00);
    clk_en = 1'b1;
    // Setting the in-progress bit wins over a same-cycle clear
    ipclr = 1'b1;
    report(7, 2'h0);
    chk({exq, cip}, 2'b11);
    @(negedge ref_clk);
    ipclr = 1'b0;
    chk(cip, 1'b0);
    // Overwriting a valid bank flags overflow, which blocks recovery
    report(4, 2'h0);
    @(negedge ref_clk);
    chk({rec, scope}, {1'b0, MCS_SCOPE_CORRECTED});
    // Disabled exceptions: corrected is quiet, uncorrected shuts down
    en = 1'b0;
    report(4, 2'h3);
    chk({exq, shut}, 2'b00);
    @(negedge ref_clk);
    report(1, 2'h1);
    chk({exq, shut}, 2'b01);
    repeat (3) @(negedge ref_clk);
    chk(shut, 1'b1);
    summarize();
  end
endmodule // mcs_scope_unit_tb_top

//--- logic/mcs_scope_unit.sv
// Machine-check error scope unit: per-bank logging, scope classification,
// exception raise and shutdown decision.
// Assumes error reports and software clears are synchronous single-cycle pulses.
`timescale 1ns/1ps
`include "mcs_params.svh"

module mcs_scope_unit (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic check_exception_enable,
  input wire logic overflow_recovery_capable,
  input wire logic err_report,
  input wire logic [`MCS_BANK_W-1:0] err_bank,
  input wire logic err_context_corrupt,
  input wire logic err_uncorrected_flag,
  input wire logic err_deferred,
  input wire logic err_poison,
  input wire logic err_overflow,
  input wire logic err_address_log_valid,
  input wire logic err_misc_log_valid,
  input wire logic err_restart_ip_valid,
  input wire logic err_error_ip_valid,
  input wire logic bank_clear,
  input wire logic [`MCS_BANK_W-1:0] clear_bank,
  input wire logic in_progress_clear,
  input wire logic [`MCS_BANK_W-1:0] view_bank,
  output logic [`MCS_NUM_BANKS-1:0] log_valid,
  output logic address_log_valid,
  output logic misc_log_valid,
  output mcs_pkg::mcs_scope_t scope,
  output logic recovery_possible,
  output logic restart_ip_valid,
  output logic error_ip_valid,
  output logic check_in_progress,
  output logic exception_req,
  output logic [`MCS_VECTOR_W-1:0] exception_vector,
  output logic shutdown
);
  import mcs_pkg::*;

  // ==========================================================
  // Per-bank log storage
  // ==========================================================
  logic [`MCS_NUM_BANKS-1:0] pcc_q, uc_q, def_q, poi_q, ovf_q, av_q, mv_q;
  logic [`MCS_NUM_BANKS-1:0] val_q;
  logic raise_d;
  logic stop_d;

  genvar gi;
  generate
    for (gi = 0; gi < `MCS_NUM_BANKS; gi++)
    begin : g_bank
      logic hit_w;
      logic clr_w;
      assign hit_w = err_report && (err_bank == `MCS_BANK_W'(gi));
      assign clr_w = bank_clear && (clear_bank == `MCS_BANK_W'(gi));
      always_ff @(posedge ref_clk)
      begin
        if (rst)
        begin
          val_q[gi] <= 1'b0;
          pcc_q[gi] <= 1'b0;
          uc_q[gi] <= 1'b0;
          def_q[gi] <= 1'b0;
          poi_q[gi] <= 1'b0;
          ovf_q[gi] <= 1'b0;
          av_q[gi] <= 1'b0;
          mv_q[gi] <= 1'b0;
        end
        else if (clk_en)
        begin
          if (hit_w)
          begin
            // New error wins over a same-cycle clear
            val_q[gi] <= 1'b1;
            pcc_q[gi] <= err_context_corrupt;
            uc_q[gi] <= err_uncorrected_flag;
            def_q[gi] <= err_deferred;
            poi_q[gi] <= err_poison;
            ovf_q[gi] <= err_overflow | (val_q[gi] & ~clr_w);
            av_q[gi] <= err_address_log_valid;
            mv_q[gi] <= err_misc_log_valid;
          end
          else if (clr_w)
          begin
            val_q[gi] <= 1'b0;
            pcc_q[gi] <= 1'b0;
            uc_q[gi] <= 1'b0;
            def_q[gi] <= 1'b0;
            poi_q[gi] <= 1'b0;
            ovf_q[gi] <= 1'b0;
            av_q[gi] <= 1'b0;
            mv_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      log_valid <= '0;
    else if (clk_en)
      log_valid <= val_q;
  end

  // ==========================================================
  // Global instruction-pointer qualifiers
  // ==========================================================
  // Restart and error pointer qualifiers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      restart_ip_valid <= 1'b0;
      error_ip_valid <= 1'b0;
    end
    else if (clk_en && raise_d)
    begin
      restart_ip_valid <= err_restart_ip_valid;
      error_ip_valid <= err_error_ip_valid;
    end
  end

  // ==========================================================
  // Scope classification of the viewed bank
  // ==========================================================
  logic v_val, v_pcc, v_uc, v_def, v_poi, v_ovf;
  mcs_scope_t scope_d;
  assign v_val = val_q[view_bank];
  assign v_pcc = pcc_q[view_bank];
  assign v_uc = uc_q[view_bank];
  assign v_def = def_q[view_bank];
  assign v_poi = poi_q[view_bank];
  assign v_ovf = ovf_q[view_bank];

  always_comb
  begin
    scope_d = MCS_SCOPE_UNCLASSIFIED;
    if (!v_val)
      scope_d = MCS_SCOPE_NONE;
    else if (v_pcc && v_uc)
      scope_d = MCS_SCOPE_FATAL;
    else if (!v_pcc && v_uc && restart_ip_valid && error_ip_valid)
      scope_d = MCS_SCOPE_RECOVERABLE;
    else if (!v_pcc && v_uc && !restart_ip_valid)
      scope_d = MCS_SCOPE_CONTAINABLE;
    else if (!v_pcc && !v_uc && v_def && !v_poi)
      scope_d = MCS_SCOPE_DEFERRED;
    else if (!v_pcc && !v_uc && !v_def && !v_poi)
      scope_d = MCS_SCOPE_CORRECTED;
    else
      scope_d = MCS_SCOPE_UNCLASSIFIED;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      scope <= MCS_SCOPE_NONE;
      recovery_possible <= 1'b0;
      address_log_valid <= 1'b0;
      misc_log_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      scope <= scope_d;
      recovery_possible <= v_val && !v_pcc && !(v_ovf && !overflow_recovery_capable);
      address_log_valid <= av_q[view_bank];
      misc_log_valid <= mv_q[view_bank];
    end
  end

  // ==========================================================
  // Exception raise and shutdown
  // ==========================================================
  // Only uncorrected errors raise
  assign raise_d = err_report && err_uncorrected_flag && !shutdown;
  assign stop_d = raise_d && (check_in_progress || !check_exception_enable);

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      check_in_progress <= 1'b0;
    else if (clk_en)
    begin
      if (raise_d && check_exception_enable)
        check_in_progress <= 1'b1;
      else if (in_progress_clear)
        check_in_progress <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
      shutdown <= 1'b0;
    else if (clk_en && stop_d)
      shutdown <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      exception_req <= 1'b0;
      exception_vector <= '0;
    end
    else if (clk_en)
    begin
      exception_req <= raise_d && !stop_d;
      exception_vector <= `MCS_VECTOR;
    end
  end

  // ==========================================================
  // Assertions
  // ==========================================================
  property p_fatal;
    @(posedge ref_clk) disable iff (rst)
      clk_en && v_val && v_pcc && v_uc |=> scope == MCS_SCOPE_FATAL;
  endproperty
  a_fatal: assert property (p_fatal) else $error("fatal scope missed");

  property p_contain;
    @(posedge ref_clk) disable iff (rst)
      clk_en && v_val && !v_pcc && v_uc && !restart_ip_valid
      |=> scope == MCS_SCOPE_CONTAINABLE;
  endproperty
  a_contain: assert property (p_contain) else $error("containable scope missed");

  property p_corrected;
    @(posedge ref_clk) disable iff (rst)
      clk_en && v_val && !v_pcc && !v_uc && !v_def && !v_poi
      |=> scope == MCS_SCOPE_CORRECTED;
  endproperty
  a_corrected: assert property (p_corrected) else $error("corrected scope missed");

  property p_no_raise_corr;
    @(posedge ref_clk) disable iff (rst)
      clk_en && err_report && !err_uncorrected_flag |=> !exception_req;
  endproperty
  a_no_raise_corr: assert property (p_no_raise_corr) else $error("raised on corrected");

  property p_second;
    @(posedge ref_clk) disable iff (rst)
      clk_en && check_in_progress && raise_d |=> shutdown && !exception_req;
  endproperty
  a_second: assert property (p_second) else $error("no shutdown on nested check");

  property p_disabled;
    @(posedge ref_clk) disable iff (rst)
      clk_en && raise_d && !check_exception_enable |=> shutdown ##1 shutdown;
  endproperty
  a_disabled: assert property (p_disabled) else $error("no shutdown when disabled");

  property p_recov;
    @(posedge ref_clk) disable iff (rst)
      clk_en && v_pcc |=> !recovery_possible;
  endproperty
  a_recov: assert property (p_recov) else $error("recovery claimed when corrupt");

  property p_relog;
    @(posedge ref_clk) disable iff (rst)
      clk_en && err_report |=> clk_en [*1] |=> log_valid[$past(err_bank, 2)];
  endproperty
  a_relog: assert property (p_relog) else $error("log not recorded");

  c_fatal: cover property (@(posedge ref_clk) scope == MCS_SCOPE_FATAL);
  c_exc: cover property (@(posedge ref_clk) exception_req);
  c_shut: cover property (@(posedge ref_clk) $rose(shutdown));
endmodule // mcs_scope_unit

//--- shared/mcs_params.svh
// Constants for the machine-check error scope unit.
// Assumes a single 50 MHz core clock and synchronous active-high reset.
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH
`define MCS_NUM_BANKS 4
`define MCS_BANK_W 2
`define MCS_BANK_COUNT_RST 2'h0
`define MCS_VECTOR 8'h12
`define MCS_VECTOR_W 8
`endif

//--- shared/mcs_pkg.sv
// Types for the machine-check error scope unit.
// Assumes the constants header is included by users.
package mcs_pkg;
  typedef enum logic [2:0] {
    MCS_SCOPE_NONE,
    MCS_SCOPE_FATAL,
    MCS_SCOPE_RECOVERABLE,
    MCS_SCOPE_CONTAINABLE,
    MCS_SCOPE_DEFERRED,
    MCS_SCOPE_CORRECTED,
    MCS_SCOPE_UNCLASSIFIED
  } mcs_scope_t;
endpackage
